// file: core/rfb_pkg.sv
// rfb_pkg: register map, field positions and carriers for the free-buffer / link-mode block
package rfb_pkg;
	localparam int          RFB_NUM_CH        = 8;
	localparam int          RFB_CNT_W         = 16;
	localparam int          RFB_THR_W         = 8;
	localparam int          RFB_ADDR_W        = 8;
	// byte addresses of the register words
	localparam logic [7:0]  RFB_OFF_FREE0     = 8'h00;
	localparam logic [7:0]  RFB_OFF_FLOW0     = 8'h20;
	localparam logic [7:0]  RFB_OFF_FILTER    = 8'h40;
	localparam logic [7:0]  RFB_OFF_LINKCTRL  = 8'h44;
	localparam logic [7:0]  RFB_OFF_LINKSTAT  = 8'h48;
	// link mode control field positions
	localparam int          RFB_BIT_RMIIDUP   = 16;
	localparam int          RFB_BIT_SPDFORCE  = 17;
	localparam int          RFB_BIT_INBAND    = 18;
	localparam int          RFB_BIT_FULLDUP   = 0;
	localparam int          RFB_BIT_FLOWEN    = 3;
	localparam int          RFB_BIT_GIG       = 7;
	localparam logic [31:0] RFB_CTRL_WMASK    = 32'h0007_0089;
	localparam logic [31:0] RFB_CTRL_RESET    = 32'h0000_0000;
	localparam logic [15:0] RFB_CNT_RESET     = 16'h0000;
	localparam logic [7:0]  RFB_THR_RESET     = 8'h00;
	localparam logic [1:0]  RFB_RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RFB_RESP_SLVERR   = 2'b10;

	typedef struct packed {
		logic fullDuplex;
		logic gigabit;
		logic speedForce;
		logic rmiiFullDuplex;
		logic inbandStatusEnable;
	} rfb_link_t;

	typedef enum logic [2:0] {
		RFB_W_IDLE = 3'b001,
		RFB_W_DO   = 3'b010,
		RFB_W_RESP = 3'b100
	} rfb_wstate_t;
endpackage : rfb_pkg

// file: core/rfb_free_counter.sv
// rfb_free_counter: one channel's write-to-increment free-buffer counter
`timescale 1ns/100ps
`default_nettype none
module rfb_free_counter
	import rfb_pkg::*;
#(
	parameter int CNT_W = RFB_CNT_W
)(
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              incValid,
	input  wire logic [CNT_W-1:0]  incAmount,
	input  wire logic              decValid,
	input  wire logic [CNT_W-1:0]  decAmount,
	output var  logic [CNT_W-1:0]  count
);
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;

	// increment and decrement in one cycle both apply; neither is lost
	always_comb
	begin
		nxt_count = count_ff;
		if (incValid)
			nxt_count = nxt_count + incAmount;
		if (decValid)
			nxt_count = nxt_count - decAmount;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			count_ff <= CNT_W'(RFB_CNT_RESET);
		else
			count_ff <= nxt_count;
	end

	assign count = count_ff;

	property p_inc_wraps;
		@(posedge sys_clk) disable iff (!resetn)
		(incValid && !decValid) |=> (count_ff == $past(count_ff) + $past(incAmount));
	endproperty
	a_inc_wraps: assert property (p_inc_wraps)
		else $error("free count did not add written value");

	property p_dec;
		@(posedge sys_clk) disable iff (!resetn)
		(decValid && !incValid) |=> (count_ff == $past(count_ff) - $past(decAmount));
	endproperty
	a_dec: assert property (p_dec)
		else $error("free count did not drop by frame buffers");

	property p_hold;
		@(posedge sys_clk) disable iff (!resetn)
		(!decValid && !incValid) |=> $stable(count_ff);
	endproperty
	a_hold: assert property (p_hold)
		else $error("free count changed without cause");
endmodule : rfb_free_counter
`default_nettype wire

// file: core/rfb_top.sv
// rfb_top: receive free-buffer accounting and link mode control over AXI4-Lite
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rfb_top
	import rfb_pkg::*;
#(
	parameter int NUM_CH = RFB_NUM_CH,
	parameter int CNT_W  = RFB_CNT_W
)(
	input  wire logic                      sys_clk,
	input  wire logic                      resetn,
	input  wire logic [RFB_ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output var  logic                      s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output var  logic                      s_axi_wready,
	output var  logic [1:0]                s_axi_bresp,
	output var  logic                      s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [RFB_ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output var  logic                      s_axi_arready,
	output var  logic [31:0]               s_axi_rdata,
	output var  logic [1:0]                s_axi_rresp,
	output var  logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      frameRxValid,
	input  wire logic [$clog2(NUM_CH)-1:0] frameRxChannel,
	input  wire logic [CNT_W-1:0]          frameRxBuffers,
	input  wire logic                      frameRxLowPriority,
	input  wire logic                      inbandDuplexIn,
	input  wire logic                      inbandGigabitIn,
	output var  logic                      lowPriorityFilter,
	output var  logic [NUM_CH-1:0]         rxFlowAssert,
	output var  rfb_link_t                 linkMode
);
	localparam int CH_W = $clog2(NUM_CH);

	// link pins come from the phy side: three flops, accept on agreement
	logic [2:0] dupSync_ff;
	logic [2:0] gigSync_ff;
	logic       dupFilt_ff;
	logic       gigFilt_ff;
	logic       nxt_dupFilt;
	logic       nxt_gigFilt;

	logic [31:0]       ctrl_ff;
	logic [31:0]       nxt_ctrl;
	logic [RFB_THR_W-1:0] filterThr_ff;
	logic [RFB_THR_W-1:0] nxt_filterThr;
	logic [RFB_THR_W-1:0] flowThr_ff [NUM_CH];
	logic [RFB_THR_W-1:0] nxt_flowThr [NUM_CH];
	logic [CNT_W-1:0]  freeCount [NUM_CH];
	logic [NUM_CH-1:0] incValid;

	rfb_wstate_t       wState_ff;
	rfb_wstate_t       nxt_wState;
	logic              awHave_ff;
	logic              wHave_ff;
	logic [RFB_ADDR_W-1:0] awAddr_ff;
	logic [31:0]       wData_ff;
	logic [3:0]        wStrb_ff;
	logic              nxt_awHave;
	logic              nxt_wHave;
	logic [RFB_ADDR_W-1:0] nxt_awAddr;
	logic [31:0]       nxt_wData;
	logic [3:0]        nxt_wStrb;
	logic [1:0]        bResp_ff;
	logic [1:0]        nxt_bResp;

	logic              rValid_ff;
	logic              nxt_rValid;
	logic [31:0]       rData_ff;
	logic [31:0]       nxt_rData;
	logic [1:0]        rResp_ff;
	logic [1:0]        nxt_rResp;

	logic              filter_ff;
	logic              nxt_filter;
	logic [NUM_CH-1:0] flow_ff;
	logic [NUM_CH-1:0] nxt_flow;
	rfb_link_t         link_ff;
	rfb_link_t         nxt_link;

	logic [31:0] wMask;
	logic        wHit;
	logic [CH_W-1:0] wCh;

	assign wMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
	assign wCh   = awAddr_ff[CH_W+1:2];
	// refused (slverr) writes must leave every register and counter alone
	assign wHit  = (wState_ff == RFB_W_DO) && (nxt_bResp == RFB_RESP_OKAY);

	// write channel: collect address and data in any order, one write at a time
	always_comb
	begin
		nxt_wState = wState_ff;
		nxt_awHave = awHave_ff;
		nxt_wHave  = wHave_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wData  = wData_ff;
		nxt_wStrb  = wStrb_ff;
		nxt_bResp  = bResp_ff;
		case (wState_ff)
			RFB_W_IDLE:
			begin
				if (s_axi_awvalid && !awHave_ff)
				begin
					nxt_awHave = 1'b1;
					nxt_awAddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && !wHave_ff)
				begin
					nxt_wHave = 1'b1;
					nxt_wData = s_axi_wdata;
					nxt_wStrb = s_axi_wstrb;
				end
				if (nxt_awHave && nxt_wHave)
					nxt_wState = RFB_W_DO;
			end
			RFB_W_DO:
			begin
				nxt_awHave = 1'b0;
				nxt_wHave  = 1'b0;
				nxt_bResp  = RFB_RESP_OKAY;
				if (awAddr_ff > RFB_OFF_LINKCTRL || awAddr_ff[1:0] != 2'b00)
					nxt_bResp = RFB_RESP_SLVERR;
				nxt_wState = RFB_W_RESP;
			end
			RFB_W_RESP:
				if (s_axi_bready)
					nxt_wState = RFB_W_IDLE;
			default:
				nxt_wState = RFB_W_IDLE;
		endcase
	end

	// register writes; only documented bits accept data
	always_comb
	begin
		nxt_ctrl      = ctrl_ff;
		nxt_filterThr = filterThr_ff;
		nxt_flowThr   = flowThr_ff;
		incValid      = '0;
		if (wHit)
		begin
			if (awAddr_ff == RFB_OFF_LINKCTRL)
				nxt_ctrl = (ctrl_ff & ~(wMask & RFB_CTRL_WMASK))
					| (wData_ff & wMask & RFB_CTRL_WMASK);
			if (awAddr_ff == RFB_OFF_FILTER && wStrb_ff[0])
				nxt_filterThr = wData_ff[RFB_THR_W-1:0];
			if (awAddr_ff[7:5] == RFB_OFF_FLOW0[7:5] && wStrb_ff[0])
				nxt_flowThr[wCh] = wData_ff[RFB_THR_W-1:0];
			if (awAddr_ff[7:5] == RFB_OFF_FREE0[7:5])
				incValid[wCh] = 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++)
		begin : g_ch
			rfb_free_counter #(
				.CNT_W     (CNT_W)
			) u_cnt (
				.sys_clk   (sys_clk),
				.resetn    (resetn),
				.incValid  (incValid[gi]),
				.incAmount (wData_ff[CNT_W-1:0] & wMask[CNT_W-1:0]),
				.decValid  (frameRxValid && frameRxChannel == CH_W'(gi)),
				.decAmount (frameRxBuffers),
				.count     (freeCount[gi])
			);
			assign nxt_flow[gi] = ctrl_ff[RFB_BIT_FLOWEN]
				&& (freeCount[gi] < CNT_W'(flowThr_ff[gi]));
		end
	endgenerate

	assign nxt_filter = frameRxLowPriority
		&& (freeCount[frameRxChannel] < CNT_W'(filterThr_ff));

	// read channel: one cycle to answer, held until rready
	always_comb
	begin
		nxt_rValid = rValid_ff;
		nxt_rData  = rData_ff;
		nxt_rResp  = rResp_ff;
		if (rValid_ff && s_axi_rready)
			nxt_rValid = 1'b0;
		else if (!rValid_ff && s_axi_arvalid)
		begin
			nxt_rValid = 1'b1;
			nxt_rResp  = RFB_RESP_OKAY;
			nxt_rData  = 32'h0000_0000;
			if (s_axi_araddr[1:0] != 2'b00)
				nxt_rResp = RFB_RESP_SLVERR;
			else if (s_axi_araddr[7:5] == RFB_OFF_FREE0[7:5])
				nxt_rData[CNT_W-1:0] = freeCount[s_axi_araddr[CH_W+1:2]];
			else if (s_axi_araddr[7:5] == RFB_OFF_FLOW0[7:5])
				nxt_rData[RFB_THR_W-1:0] = flowThr_ff[s_axi_araddr[CH_W+1:2]];
			else if (s_axi_araddr == RFB_OFF_FILTER)
				nxt_rData[RFB_THR_W-1:0] = filterThr_ff;
			else if (s_axi_araddr == RFB_OFF_LINKCTRL)
				nxt_rData = ctrl_ff;
			else if (s_axi_araddr == RFB_OFF_LINKSTAT)
				nxt_rData[1:0] = {gigFilt_ff, dupFilt_ff};
			else
				nxt_rResp = RFB_RESP_SLVERR;
		end
	end

	// link mode resolution
	always_comb
	begin
		nxt_dupFilt = (dupSync_ff[1] == dupSync_ff[2]) ? dupSync_ff[2] : dupFilt_ff;
		nxt_gigFilt = (gigSync_ff[1] == gigSync_ff[2]) ? gigSync_ff[2] : gigFilt_ff;
		nxt_link.inbandStatusEnable = ctrl_ff[RFB_BIT_INBAND];
		nxt_link.fullDuplex = ctrl_ff[RFB_BIT_INBAND] ? dupFilt_ff : ctrl_ff[RFB_BIT_FULLDUP];
		nxt_link.gigabit    = ctrl_ff[RFB_BIT_SPDFORCE]
			|| (ctrl_ff[RFB_BIT_INBAND] ? gigFilt_ff : ctrl_ff[RFB_BIT_GIG]);
		nxt_link.speedForce = ctrl_ff[RFB_BIT_SPDFORCE];
		nxt_link.rmiiFullDuplex = ctrl_ff[RFB_BIT_RMIIDUP];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			wState_ff    <= RFB_W_IDLE;
			awHave_ff    <= 1'b0;
			wHave_ff     <= 1'b0;
			awAddr_ff    <= '0;
			wData_ff     <= 32'h0000_0000;
			wStrb_ff     <= 4'h0;
			bResp_ff     <= RFB_RESP_OKAY;
			rValid_ff    <= 1'b0;
			rData_ff     <= 32'h0000_0000;
			rResp_ff     <= RFB_RESP_OKAY;
			ctrl_ff      <= RFB_CTRL_RESET;
			filterThr_ff <= RFB_THR_RESET;
			flowThr_ff   <= '{default: RFB_THR_RESET};
			filter_ff    <= 1'b0;
			flow_ff      <= '0;
			link_ff      <= '0;
			dupSync_ff   <= 3'h0;
			gigSync_ff   <= 3'h0;
			dupFilt_ff   <= 1'b0;
			gigFilt_ff   <= 1'b0;
		end
		else
		begin
			wState_ff    <= nxt_wState;
			awHave_ff    <= nxt_awHave;
			wHave_ff     <= nxt_wHave;
			awAddr_ff    <= nxt_awAddr;
			wData_ff     <= nxt_wData;
			wStrb_ff     <= nxt_wStrb;
			bResp_ff     <= nxt_bResp;
			rValid_ff    <= nxt_rValid;
			rData_ff     <= nxt_rData;
			rResp_ff     <= nxt_rResp;
			ctrl_ff      <= nxt_ctrl;
			filterThr_ff <= nxt_filterThr;
			flowThr_ff   <= nxt_flowThr;
			filter_ff    <= nxt_filter;
			flow_ff      <= nxt_flow;
			link_ff      <= nxt_link;
			dupSync_ff   <= {dupSync_ff[1:0], inbandDuplexIn};
			gigSync_ff   <= {gigSync_ff[1:0], inbandGigabitIn};
			dupFilt_ff   <= nxt_dupFilt;
			gigFilt_ff   <= nxt_gigFilt;
		end
	end

	// ready only in idle and only for a half not yet held
	assign s_axi_awready     = (wState_ff == RFB_W_IDLE) && !awHave_ff;
	assign s_axi_wready      = (wState_ff == RFB_W_IDLE) && !wHave_ff;
	assign s_axi_bvalid      = (wState_ff == RFB_W_RESP);
	assign s_axi_bresp       = bResp_ff;
	assign s_axi_arready     = !rValid_ff;
	assign s_axi_rvalid      = rValid_ff;
	assign s_axi_rdata       = rData_ff;
	assign s_axi_rresp       = rResp_ff;
	assign lowPriorityFilter = filter_ff;
	assign rxFlowAssert      = flow_ff;
	assign linkMode          = link_ff;

	property p_inband_direct;
		@(posedge sys_clk) disable iff (!resetn)
		1'b1 |=> (link_ff.inbandStatusEnable == $past(ctrl_ff[RFB_BIT_INBAND]));
	endproperty
	a_inband_direct: assert property (p_inband_direct)
		else $error("inband enable not following control bit");

	property p_forced;
		@(posedge sys_clk) disable iff (!resetn)
		(!ctrl_ff[RFB_BIT_INBAND] && !ctrl_ff[RFB_BIT_SPDFORCE])
			|=> (link_ff.fullDuplex == $past(ctrl_ff[RFB_BIT_FULLDUP])
			&& link_ff.gigabit == $past(ctrl_ff[RFB_BIT_GIG]));
	endproperty
	a_forced: assert property (p_forced)
		else $error("forced link mode not taken from bits");

	property p_inband;
		@(posedge sys_clk) disable iff (!resetn)
		ctrl_ff[RFB_BIT_INBAND] |=> (link_ff.fullDuplex == $past(dupFilt_ff));
	endproperty
	a_inband: assert property (p_inband)
		else $error("inband duplex not used");

	property p_force_gig;
		@(posedge sys_clk) disable iff (!resetn)
		ctrl_ff[RFB_BIT_SPDFORCE] |=> link_ff.gigabit;
	endproperty
	a_force_gig: assert property (p_force_gig)
		else $error("speed force did not give gigabit");

	property p_flow_off;
		@(posedge sys_clk) disable iff (!resetn)
		!ctrl_ff[RFB_BIT_FLOWEN] |=> (flow_ff == '0);
	endproperty
	a_flow_off: assert property (p_flow_off)
		else $error("flow asserted while disabled");

	property p_reserved;
		@(posedge sys_clk) disable iff (!resetn)
		(ctrl_ff & ~RFB_CTRL_WMASK) == 32'h0000_0000;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved control bit set");

	property p_filter_zero;
		@(posedge sys_clk) disable iff (!resetn)
		(filterThr_ff == 8'h00) |=> !filter_ff;
	endproperty
	a_filter_zero: assert property (p_filter_zero)
		else $error("filter active with zero threshold");

	property p_bresp_hold;
		@(posedge sys_clk) disable iff (!resetn)
		(s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
	endproperty
	a_bresp_hold: assert property (p_bresp_hold)
		else $error("write response dropped before taken");
endmodule : rfb_top
`default_nettype wire

// file: sim/rfb_phy_model.sv
// rfb_phy_model: PHY stand-in that reports link status in-band
`timescale 1ns/100ps
`default_nettype none
module rfb_phy_model #(
	parameter realtime LAG = 3.3
)(
	input  wire logic statusDuplex,
	input  wire logic statusGigabit,
	output var  logic inbandDuplexIn,
	output var  logic inbandGigabitIn
);
	initial
	begin
		inbandDuplexIn  = 1'b0;
		inbandGigabitIn = 1'b0;
	end
	// in-band status
	// pins move off the core clock, so the core must resynchronise them
	always @(statusDuplex or statusGigabit)
	begin
		inbandDuplexIn  <= #(LAG) statusDuplex;
		inbandGigabitIn <= #(LAG) statusGigabit;
	end
endmodule : rfb_phy_model
`default_nettype wire

// file: sim/rfb_top_tb.sv
// rfb_top_tb: self-checking bench for free-buffer counts and link mode
`timescale 1ns/100ps
`default_nettype none
module rfb_top_tb
	import rfb_pkg::*;
;
	logic        sys_clk, resetn, phyDup, phyGig;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        frameRxValid, frameRxLowPriority, inbandDuplexIn, inbandGigabitIn;
	logic [2:0]  frameRxChannel;
	logic [15:0] frameRxBuffers;
	logic        lowPriorityFilter;
	logic [7:0]  rxFlowAssert;
	rfb_link_t   linkMode;
	int          failures, cmp_count, cycles;
	localparam logic [31:0] LINK_W [8] = '{32'hFFFF_FFFF, 32'h89, 32'h1, 32'h4_0000,
		32'h4_0000, 32'h4_0081, 32'h2_0000, 32'h1_0000};
	localparam logic [4:0]  LINK_E [8] = '{5'h0F, 5'h18, 5'h10, 5'h19, 5'h11, 5'h01, 5'h0C, 5'h02};
	localparam logic [1:0]  LINK_S [8] = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h1, 2'h0, 2'h0, 2'h0};

	rfb_top rfb_top_i (.sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frameRxValid(frameRxValid),
		.frameRxChannel(frameRxChannel), .frameRxBuffers(frameRxBuffers),
		.frameRxLowPriority(frameRxLowPriority), .inbandDuplexIn(inbandDuplexIn),
		.inbandGigabitIn(inbandGigabitIn), .lowPriorityFilter(lowPriorityFilter),
		.rxFlowAssert(rxFlowAssert), .linkMode(linkMode));

	rfb_phy_model rfb_phy_model_i (.statusDuplex(phyDup), .statusGigabit(phyGig),
		.inbandDuplexIn(inbandDuplexIn), .inbandGigabitIn(inbandGigabitIn));

	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	// a hung handshake ends here instead of running on
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			failures++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// let the release stand one edge before the next request
		@(posedge sys_clk);
	endtask : axiWrite

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask : axiRead

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axiWrite(a, d, r);
		chk("bresp", {30'h0, r}, {30'h0, RFB_RESP_OKAY});
	endtask : wr

	task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axiRead(a, d, r);
		chk(nm, d, exp);
		chk("rresp", {30'h0, r}, {30'h0, RFB_RESP_OKAY});
	endtask : rdChk

	task automatic outChk(input string nm, input bit isFlow, input logic [31:0] exp);
		repeat (3) @(posedge sys_clk);
		// outputs are read after the wait, not when the task is called
		chk(nm, isFlow ? {24'h0, rxFlowAssert} : {31'h0, lowPriorityFilter}, exp);
	endtask : outChk

	task automatic testReset();
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		chk("linkMode", {27'h0, linkMode}, 32'h0);
		chk("rxFlowAssert", {24'h0, rxFlowAssert}, 32'h0);
		rdChk("ch3 count", 8'h0C, 32'h0);
		rdChk("link ctrl", RFB_OFF_LINKCTRL, 32'h0);
	endtask : testReset

	task automatic testCounters();
		wr(8'h0C, 32'h0000_0010);
		rdChk("ch3 load", 8'h0C, 32'h10);
		wr(8'h0C, 32'hABCD_0010);
		rdChk("ch3 add", 8'h0C, 32'h20);
		wr(8'h0C, 32'h0000_FFF0);
		rdChk("ch3 wrap", 8'h0C, 32'h10);
		frameRxChannel <= 3'd3;
		frameRxBuffers <= 16'h0004;
		frameRxValid   <= 1'b1;
		@(posedge sys_clk);
		frameRxValid   <= 1'b0;
		rdChk("ch3 frame", 8'h0C, 32'h0C);
		wr(8'h1C, 32'h0000_0001);
		wr(8'h1C, 32'h0000_FFFF);
		rdChk("ch7 to zero", 8'h1C, 32'h0);
		rdChk("ch0 untouched", RFB_OFF_FREE0, 32'h0);
	endtask : testCounters

	task automatic testFlow();
		wr(8'h2C, 32'hFFFF_FF20);
		rdChk("flow thr", 8'h2C, 32'h20);
		outChk("flow off", 1'b1, 32'h0);
		wr(RFB_OFF_LINKCTRL, 32'h0000_0008);
		outChk("flow on", 1'b1, 32'h08);
		wr(8'h0C, 32'h0000_0014);
		outChk("flow at thr", 1'b1, 32'h0);
	endtask : testFlow

	task automatic testFilter();
		wr(RFB_OFF_FILTER, 32'hFFFF_FF21);
		rdChk("filter thr", RFB_OFF_FILTER, 32'h21);
		frameRxLowPriority <= 1'b1;
		outChk("filter below", 1'b0, 32'h1);
		wr(RFB_OFF_FILTER, 32'h0);
		outChk("filter zero", 1'b0, 32'h0);
		wr(RFB_OFF_FILTER, 32'h21);
		frameRxLowPriority <= 1'b0;
		outChk("filter high prio", 1'b0, 32'h0);
	endtask : testFilter

	task automatic testLink();
		for (int i = 0; i < 8; i++)
		begin
			phyDup <= LINK_S[i][0];
			phyGig <= LINK_S[i][1];
			wr(RFB_OFF_LINKCTRL, LINK_W[i]);
			repeat (8) @(posedge sys_clk);
			chk("linkMode", {27'h0, linkMode}, {27'h0, LINK_E[i]});
			rdChk("ctrl back", RFB_OFF_LINKCTRL, LINK_W[i] & RFB_CTRL_WMASK);
			rdChk("link status", RFB_OFF_LINKSTAT, {30'h0, LINK_S[i]});
		end
	endtask : testLink

	task automatic testBadAddr();
		logic [31:0] d;
		logic [1:0]  r;
		axiRead(8'h4C, d, r);
		chk("rresp unmapped", {30'h0, r}, {30'h0, RFB_RESP_SLVERR});
		axiWrite(8'h48, 32'h3, r);
		chk("bresp status", {30'h0, r}, {30'h0, RFB_RESP_SLVERR});
		axiWrite(8'h01, 32'h1, r);
		chk("bresp unaligned", {30'h0, r}, {30'h0, RFB_RESP_SLVERR});
		rdChk("ch0 after bad", RFB_OFF_FREE0, 32'h0);
	endtask : testBadAddr

	initial
	begin
		{resetn, phyDup, phyGig, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, frameRxValid, frameRxLowPriority} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, frameRxChannel, frameRxBuffers} = '0;
		s_axi_wstrb = 4'hF;
		failures    = 0;
		cmp_count   = 0;
		cycles      = 0;
		@(posedge sys_clk);
		testReset();
		testCounters();
		testFlow();
		testFilter();
		testLink();
		testBadAddr();
		testReset();
		end_of_test();
	end
endmodule : rfb_top_tb
`default_nettype wire
